// *** cdcc_pkg.sv ***
// package with register map, fields and timing constants for the card supply converter control
package cdcc_pkg;
   // register byte addresses (apb, 32-bit aligned words)
   localparam logic [11:0] CDCC_CONV_CTRL_IDX  = 12'h0bf;
   localparam logic [11:0] CDCC_CONV_CTRL_ADDR = 12'h2fc;
   localparam logic [11:0] CDCC_CARD_IF_CTRL   = 12'h000;
   localparam logic [11:0] CDCC_CARD_CTRL      = 12'h004;
   localparam logic [11:0] CDCC_CARD_IF_STAT   = 12'h008;
   // converter control fields
   localparam int          CDCC_MODE_BIT       = 7;
   localparam int          CDCC_OCADJ_BIT      = 6;
   localparam int          CDCC_BOOST_LSB      = 4;
   localparam int          CDCC_DIV_LSB        = 0;
   localparam logic [7:0]  CDCC_CONV_RST       = 8'h00;
   // card interface control / card control / status fields
   localparam int          CDCC_VSEL_LSB       = 0;
   localparam int          CDCC_SUPPLY_ON_BIT  = 0;
   localparam int          CDCC_VGOOD_BIT      = 0;
   localparam int          CDCC_OVC_BIT        = 1;
   localparam int          CDCC_RUN_BIT        = 2;
   localparam logic [1:0]  CDCC_VSEL_RST       = 2'h0;
   // overcurrent level in percent of the 100 ma base, without and with the adjust bit
   localparam logic [7:0]  CDCC_LVL_BASE       = 8'h64;
   localparam logic [7:0]  CDCC_LVL_ADJ        = 8'h78;
   // startup: cycles of converter clock allowed before giving up
   localparam logic [15:0] CDCC_START_TICKS    = 16'h0fa0;
   // shutdown sequence length in converter clock ticks
   localparam logic [3:0]  CDCC_STOP_TICKS     = 4'h4;
   typedef enum logic [2:0] {
      CDCC_OFF, CDCC_START, CDCC_RUN, CDCC_STOP, CDCC_TRIP
   } cdcc_state_e;
endpackage

// *** cdcc_prescaler.sv ***
// converter clock prescaler: one-cycle enable at pclk divided by the coded factor
`timescale 1ns/100ps
module cdcc_prescaler
   import cdcc_pkg::*;
(
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] div_code,
   output logic            tick
);
   logic [4:0] cnt_r;
   logic [4:0] cnt_nxt;
   logic       tick_r;
   logic       tick_nxt;
   logic [4:0] div_m1;

   // code 0 (reset) gives divide by 2, i.e. 4 mhz from an 8 mhz crystal
   always_comb begin
      unique case (div_code)
         4'h0:    div_m1 = 5'h01;
         4'h1:    div_m1 = 5'h03;
         4'h2:    div_m1 = 5'h04;
         4'h3:    div_m1 = 5'h05;
         4'h4:    div_m1 = 5'h07;
         4'h5:    div_m1 = 5'h09;
         4'h6:    div_m1 = 5'h0b;
         4'h7:    div_m1 = 5'h17;
         default: div_m1 = 5'h01;
      endcase
   end

   always_comb begin
      tick_nxt = 1'b0;
      cnt_nxt  = cnt_r + 5'h01;
      if (cnt_r >= div_m1) begin // RULE11
         cnt_nxt  = 5'h00;
         tick_nxt = 1'b1;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_r  <= 5'h00;
         tick_r <= 1'b0;
      end else begin
         cnt_r  <= cnt_nxt;
         tick_r <= tick_nxt;
      end
   end

   assign tick = tick_r;

   tick_pulse_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      tick_r |=> !tick_r) else $error("prescaler tick longer than one cycle");
endmodule

// *** cdcc_stage_model.sv ***
// behavioural card supply power stage: rail ramp on converter ticks, injectable short
`timescale 1ns/100ps
module cdcc_stage_model #(
   parameter int RAMP_TICKS = 16
) (
   input  wire logic pclk,
   input  wire logic presetn,
   input  wire logic conv_enable,
   input  wire logic conv_tick,
   input  wire logic short_req,
   output logic      rail_in_target,
   output logic      overcurrent_sense
);
   int ramp_r;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ramp_r            <= 0;
         rail_in_target    <= 1'b0;
         overcurrent_sense <= 1'b0;
      end else begin
         // a shorted rail never climbs, so a start under a fault cannot finish
         if (!conv_enable || short_req) begin
            ramp_r <= 0;
         end else if (conv_tick && ramp_r < RAMP_TICKS) begin
            ramp_r <= ramp_r + 1;
         end
         // the rail decays at once when the stage is off
         rail_in_target    <= conv_enable && !short_req && ramp_r >= RAMP_TICKS;
         overcurrent_sense <= conv_enable && short_req;
      end
   end
endmodule

// *** cdcc_top.sv ***
// card supply converter control: apb registers, supply gating, startup and trip logic
// Functional notes
// RULE1: converter never turns on while card presence is inactive.
// RULE2: card removal while running starts an automatic shutdown.
// RULE3: firmware switches converter off before power-down.
// RULE4: control bit 7 selects pump (0) or regulator (1) mode.
// RULE5: control bit 6 raises overcurrent limit by 20 percent.
// RULE6: overcurrent action sets the card overcurrent flag by hardware.
// RULE7: boost field 00 keeps limit, 01/10/11 add 30/50/80 percent.
// RULE8: boost steps raise startup current and overcurrent level proportionally.
// RULE9: startup supply current is limited to the boost level.
// RULE10: firmware programs the prescale field for a 4 mhz converter clock.
// RULE11: prescaler divides by the coded factor into an enable pulse.
// RULE12: voltage select and supply-on bits sit in separate registers.
// RULE13: firmware selects voltage, boost, supply-on, then polls voltage-good.
// RULE14: firmware picks regulator mode for 1.8 v and 3 v.
// RULE15: firmware picks pump mode for 5 v.
// RULE16: firmware steps boost up until ready, then back down.
// RULE17: overcurrent sensing off during startup; fault leaves both flags clear.
// RULE18: good clear with overcurrent set means started then tripped.
// RULE19: good set with overcurrent clear means correct; both set never occurs.
// RULE20: firmware keeps monitoring and deactivates on loss of tolerance.
// RULE21: converter control register clears to zero on reset.
//
// The APB register port was left to the implementer.
`timescale 1ns/100ps
module cdcc_top
   import cdcc_pkg::*;
(
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic [31:0]      prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire logic        card_present_input,
   input  wire logic        rail_in_target,
   input  wire logic        overcurrent_sense,
   output logic             conv_enable,
   output logic             conv_tick,
   output logic             regulator_mode,
   output logic [7:0]       overcurrent_level,
   output logic [7:0]       startup_current_level,
   output logic [1:0]       card_voltage_select
);
   logic [7:0]  ctrl_r;
   logic [7:0]  ctrl_nxt;
   logic [1:0]  vsel_r;
   logic [1:0]  vsel_nxt;
   logic        supply_on_r;
   logic        supply_on_nxt;
   logic        vgood_r;
   logic        vgood_nxt;
   logic        ovc_r;
   logic        ovc_nxt;
   logic [31:0] prdata_r;
   logic [31:0] prdata_nxt;
   logic        slverr_r;
   logic        slverr_nxt;
   logic        ready_r;
   logic        ready_nxt;
   cdcc_state_e st_r;
   cdcc_state_e st_nxt;
   logic [15:0] cnt_r;
   logic [15:0] cnt_nxt;
   logic        en_r;
   logic        en_nxt;
   logic        reg_r;
   logic [7:0]  lvl_r;
   logic [7:0]  lvl_nxt;
   logic [7:0]  slvl_r;
   logic [1:0]  vout_r;
   logic        tick;
   logic        tick_r;
   logic        setup;
   logic        wr;
   logic        rd;
   logic [7:0]  base;
   logic [9:0]  scaled;

   cdcc_prescaler u_pre (
      .pclk     (pclk),
      .presetn  (presetn),
      .div_code (ctrl_r[CDCC_DIV_LSB +: 4]),
      .tick     (tick)
   );

   // apb: no wait state, answer on the cycle after the setup phase
   assign setup = psel && !penable;
   assign wr    = psel && penable && ready_r && pwrite;
   assign rd    = psel && penable && ready_r && !pwrite;

   always_comb begin
      ready_nxt  = setup;
      slverr_nxt = 1'b0;
      prdata_nxt = 32'h0000_0000;
      if (setup) begin
         unique case (paddr)
            CDCC_CONV_CTRL_ADDR: prdata_nxt = {24'h000000, ctrl_r};
            CDCC_CARD_IF_CTRL:   prdata_nxt = {30'h0, vsel_r};
            CDCC_CARD_CTRL:      prdata_nxt = {31'h0, supply_on_r};
            CDCC_CARD_IF_STAT:   prdata_nxt = {29'h0, en_r, ovc_r, vgood_r};
            default:             slverr_nxt = 1'b1;
         endcase
      end
   end

   // overcurrent level: base from adjust bit, scaled by boost step
   always_comb begin
      base = ctrl_r[CDCC_OCADJ_BIT] ? CDCC_LVL_ADJ : CDCC_LVL_BASE; // RULE5
      unique case (ctrl_r[CDCC_BOOST_LSB +: 2]) // RULE7
         2'h0: scaled = {2'h0, base};
         2'h1: scaled = {2'h0, base} + {2'h0, base} * 10'd3 / 10'd10;
         2'h2: scaled = {2'h0, base} + {3'h0, base[7:1]};
         2'h3: scaled = {2'h0, base} + {2'h0, base} * 10'd8 / 10'd10;
      endcase
      lvl_nxt = (scaled > 10'h0ff) ? 8'hff : scaled[7:0];
   end

   // registers and supply state machine
   always_comb begin
      ctrl_nxt      = ctrl_r;
      vsel_nxt      = vsel_r;
      supply_on_nxt = supply_on_r;
      vgood_nxt     = vgood_r;
      ovc_nxt       = ovc_r;
      st_nxt        = st_r;
      cnt_nxt       = cnt_r;
      en_nxt        = en_r;
      if (wr) begin
         unique case (paddr)
            CDCC_CONV_CTRL_ADDR: ctrl_nxt = pwdata[7:0]; // RULE4
            CDCC_CARD_IF_CTRL:   vsel_nxt = pwdata[CDCC_VSEL_LSB +: 2]; // RULE12
            CDCC_CARD_CTRL:      supply_on_nxt = pwdata[CDCC_SUPPLY_ON_BIT]; // RULE12
            default: ;
         endcase
      end
      unique case (st_r)
         CDCC_OFF: begin
            en_nxt = 1'b0;
            // refused without a card; supply-on kept for a later insertion
            if (supply_on_r && card_present_input) begin // RULE1
               st_nxt    = CDCC_START;
               cnt_nxt   = 16'h0000;
               vgood_nxt = 1'b0;
               ovc_nxt   = 1'b0;
               en_nxt    = 1'b1;
            end
         end
         CDCC_START: begin
            // sensing ignored here; a stuck start just times out with flags clear
            if (!card_present_input || !supply_on_r) begin // RULE2
               st_nxt  = CDCC_STOP;
               cnt_nxt = 16'h0000;
               en_nxt  = 1'b0;
            end else if (rail_in_target) begin // RULE17
               st_nxt    = CDCC_RUN;
               vgood_nxt = 1'b1;
            end else if (tick_r) begin
               cnt_nxt = cnt_r + 16'h0001;
               if (cnt_r == CDCC_START_TICKS) begin // RULE17
                  st_nxt = CDCC_STOP;
                  cnt_nxt = 16'h0000;
                  en_nxt = 1'b0;
               end
            end
         end
         CDCC_RUN: begin
            vgood_nxt = rail_in_target;
            if (overcurrent_sense) begin // RULE6
               st_nxt    = CDCC_TRIP;
               ovc_nxt   = 1'b1; // RULE18
               vgood_nxt = 1'b0; // RULE19
               en_nxt    = 1'b0;
            end else if (!card_present_input || !supply_on_r) begin // RULE2
               st_nxt    = CDCC_STOP;
               cnt_nxt   = 16'h0000;
               vgood_nxt = 1'b0;
               en_nxt    = 1'b0;
            end
         end
         CDCC_STOP: begin
            en_nxt    = 1'b0;
            vgood_nxt = 1'b0;
            if (tick_r) begin
               cnt_nxt = cnt_r + 16'h0001;
               if (cnt_r[3:0] == CDCC_STOP_TICKS - 4'h1) begin
                  st_nxt = CDCC_OFF;
               end
            end
            if (st_nxt == CDCC_OFF && supply_on_r) begin
               // avoid a restart loop after a failed or removed start
               supply_on_nxt = 1'b0;
            end
         end
         CDCC_TRIP: begin
            en_nxt = 1'b0;
            // flag held for firmware until it drops supply-on, then reads as switched off
            if (!supply_on_nxt) begin
               st_nxt  = CDCC_OFF;
               ovc_nxt = 1'b0; // RULE18
            end
         end
         default: st_nxt = CDCC_OFF;
      endcase
      if (wr && paddr == CDCC_CARD_CTRL && !pwdata[CDCC_SUPPLY_ON_BIT]) begin
         supply_on_nxt = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_r      <= CDCC_CONV_RST; // RULE21
         vsel_r      <= CDCC_VSEL_RST;
         supply_on_r <= 1'b0;
         vgood_r     <= 1'b0;
         ovc_r       <= 1'b0;
         st_r        <= CDCC_OFF;
         cnt_r       <= 16'h0000;
         en_r        <= 1'b0;
         reg_r       <= 1'b0;
         lvl_r       <= CDCC_LVL_BASE;
         slvl_r      <= CDCC_LVL_BASE;
         vout_r      <= CDCC_VSEL_RST;
         tick_r      <= 1'b0;
         prdata_r    <= 32'h0000_0000;
         slverr_r    <= 1'b0;
         ready_r     <= 1'b0;
      end else begin
         ctrl_r      <= ctrl_nxt;
         vsel_r      <= vsel_nxt;
         supply_on_r <= supply_on_nxt;
         vgood_r     <= vgood_nxt;
         ovc_r       <= ovc_nxt;
         st_r        <= st_nxt;
         cnt_r       <= cnt_nxt;
         en_r        <= en_nxt;
         reg_r       <= ctrl_r[CDCC_MODE_BIT]; // RULE4
         lvl_r       <= lvl_nxt; // RULE8
         slvl_r      <= lvl_nxt; // RULE9
         vout_r      <= vsel_r;
         tick_r      <= tick;
         prdata_r    <= prdata_nxt;
         slverr_r    <= slverr_nxt;
         ready_r     <= ready_nxt;
      end
   end

   assign prdata                = prdata_r;
   assign pready                = ready_r;
   assign pslverr               = slverr_r;
   assign conv_enable           = en_r;
   assign conv_tick             = tick_r;
   assign regulator_mode        = reg_r;
   assign overcurrent_level     = lvl_r;
   assign startup_current_level = slvl_r;
   assign card_voltage_select   = vout_r;

   sequence s_run_trip;
      st_r == CDCC_RUN && overcurrent_sense;
   endsequence

   // a divider write landing right after a tick must not count as a wrong period
   sequence s_div2_tick;
      tick && ctrl_r[3:0] == 4'h0 ##1 ctrl_r[3:0] == 4'h0;
   endsequence

   no_card_on_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE1
      (st_r == CDCC_OFF && !card_present_input) |=> !en_r) else $error("enabled without card");
   removal_stop_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE2
      (st_r == CDCC_RUN && !card_present_input && !overcurrent_sense) |=> st_r == CDCC_STOP)
      else $error("no shutdown on card removal");
   trip_flag_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE6
      s_run_trip |=> (ovc_r && !vgood_r && !en_r)) else $error("trip flags wrong");
   flags_excl_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE19
      !(vgood_r && ovc_r)) else $error("both flags set");
   start_noovc_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE17
      st_r == CDCC_START |-> !ovc_r) else $error("overcurrent flag during startup");
   mode_out_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE4
      (wr && paddr == CDCC_CONV_CTRL_ADDR)
      |=> ##1 regulator_mode == $past(pwdata[CDCC_MODE_BIT], 2))
      else $error("mode output mismatch");
   level_base_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE5
      (ctrl_r[7:4] == 4'h0) |=> lvl_r == CDCC_LVL_BASE) else $error("base level wrong");
   boost_top_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE7
      (ctrl_r[6:4] == 3'h3) |=> lvl_r == 8'hb4) else $error("boost 80 percent wrong");
   tick_period_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE11
      s_div2_tick |-> !tick ##1 tick)
      else $error("default divide not two");
endmodule

// *** tb_top.sv ***
// self-checking bench for the card supply converter control
`timescale 1ns/100ps
module tb_top
   import cdcc_pkg::*;
;
   logic        pclk = 1'b0;
   logic        presetn = 1'b0;
   logic        psel = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite = 1'b0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0;
   logic        card_present_input = 1'b1;
   logic        short_req = 1'b0;
   logic [31:0] prdata;
   logic        pready, pslverr, rail_in_target, overcurrent_sense;
   logic        conv_enable, conv_tick, regulator_mode;
   logic [7:0]  overcurrent_level, startup_current_level;
   logic [1:0]  card_voltage_select;
   int          mismatches = 0;
   int          tests_run = 0;

   always #50 pclk = ~pclk;

   cdcc_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .card_present_input(card_present_input),
      .rail_in_target(rail_in_target), .overcurrent_sense(overcurrent_sense),
      .conv_enable(conv_enable), .conv_tick(conv_tick), .regulator_mode(regulator_mode),
      .overcurrent_level(overcurrent_level), .startup_current_level(startup_current_level),
      .card_voltage_select(card_voltage_select));

   cdcc_stage_model stage_u (.pclk(pclk), .presetn(presetn), .conv_enable(conv_enable),
      .conv_tick(conv_tick), .short_req(short_req), .rail_in_target(rail_in_target),
      .overcurrent_sense(overcurrent_sense));

   task automatic stop_test();
      if (mismatches == 0 && tests_run > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      tests_run++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask

   // one apb transfer; an edge passes first so a release is never overwritten in one step
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] rd, output logic err);
      int n;
      n = 0;
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= wr;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (n >= 20) begin
         mismatches++;
         stop_test();
      end else begin
         rd      = prdata;
         err     = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
      end
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic        e;
      apb(1'b1, a, d, r, e);
   endtask

   task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
      logic [31:0] r;
      logic        e;
      apb(1'b0, a, 32'h0, r, e);
      chk(r, exp);
   endtask

   task automatic t_reset();
      rdchk(CDCC_CONV_CTRL_ADDR, 32'h0);
      chk(overcurrent_level, 32'h64);
      chk(conv_enable, 32'h0);
   endtask

   task automatic t_fields();
      int         pct[4] = '{100, 130, 150, 180};
      logic [7:0] v, prev;
      for (int a = 0; a < 2; a++) begin
         for (int b = 0; b < 4; b++) begin
            v = {b[0], a[0], b[1:0], 4'h0};
            wr(CDCC_CONV_CTRL_ADDR, {24'h0, v});
            cyc(3);
            rdchk(CDCC_CONV_CTRL_ADDR, {24'h0, v});
            chk(regulator_mode, b[0]);
            chk(overcurrent_level, (a ? 120 : 100) * pct[b] / 100);
            if (b > 0) chk(startup_current_level > prev, 1'b1);
            prev = startup_current_level;
         end
      end
   endtask

   task automatic t_prescale();
      int dv[9] = '{2, 4, 5, 6, 8, 10, 12, 24, 2};
      int n;
      for (int c = 0; c < 9; c++) begin
         wr(CDCC_CONV_CTRL_ADDR, c);
         cyc(30);
         n = 0;
         repeat (240) begin
            @(posedge pclk);
            if (conv_tick === 1'b1) n++;
         end
         chk(n, 240 / dv[c]);
      end
      wr(CDCC_CONV_CTRL_ADDR, 32'h0);
   endtask

   task automatic t_absent();
      card_present_input <= 1'b0;
      wr(CDCC_CARD_CTRL, 32'h1);
      cyc(6);
      chk(conv_enable, 1'b0);
      rdchk(CDCC_CARD_IF_STAT, 32'h0);
      wr(CDCC_CARD_CTRL, 32'h0);
      card_present_input <= 1'b1;
   endtask

   // firmware start order: voltage, mode and boost, supply on, then poll for good
   task automatic start_conv(input logic [1:0] vs, input logic mode);
      logic [31:0] s;
      logic        e;
      int          n;
      n = 0;
      wr(CDCC_CARD_IF_CTRL, {30'h0, vs});
      wr(CDCC_CONV_CTRL_ADDR, {24'h0, mode, 7'h10});
      wr(CDCC_CARD_CTRL, 32'h1);
      do begin
         apb(1'b0, CDCC_CARD_IF_STAT, 32'h0, s, e);
         n++;
      end while (s[0] !== 1'b1 && n < 300);
      chk(s, 32'h5);
      chk(card_voltage_select, vs);
      wr(CDCC_CONV_CTRL_ADDR, {24'h0, mode, 7'h00});
   endtask

   task automatic t_remove_and_trip();
      start_conv(2'h1, 1'b1);
      card_present_input <= 1'b0;
      cyc(3);
      chk(conv_enable, 1'b0);
      cyc(20);
      rdchk(CDCC_CARD_CTRL, 32'h0);
      card_present_input <= 1'b1;
      start_conv(2'h3, 1'b0);
      short_req <= 1'b1;
      cyc(3);
      rdchk(CDCC_CARD_IF_STAT, 32'h2);
      chk(conv_enable, 1'b0);
      short_req <= 1'b0;
      wr(CDCC_CARD_CTRL, 32'h0);
      cyc(20);
      rdchk(CDCC_CARD_IF_STAT, 32'h0);
   endtask

   task automatic t_start_fault();
      int n;
      n = 0;
      short_req <= 1'b1;
      wr(CDCC_CARD_CTRL, 32'h1);
      cyc(2);
      while (conv_enable === 1'b1 && n < 9000) begin
         @(posedge pclk);
         n++;
      end
      chk(n > 7900 && n < 9000, 1'b1);
      rdchk(CDCC_CARD_IF_STAT, 32'h0);
      short_req <= 1'b0;
      wr(CDCC_CARD_CTRL, 32'h0);
   endtask

   task automatic t_unmapped();
      logic [31:0] r;
      logic        e;
      wr(12'h100, 32'hff);
      apb(1'b0, 12'h100, 32'h0, r, e);
      chk({r[30:0], e}, 32'h1);
   endtask

   initial begin
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      t_reset();
      t_fields();
      t_prescale();
      t_absent();
      t_remove_and_trip();
      t_start_fault();
      t_unmapped();
      stop_test();
   end
endmodule
